/* File: design/gpp_pkg.sv */
// Purpose: Shared constants for the general purpose pin port.
// Assumes: One management register word is 16 bits wide.
// Notes:   Register offsets are word addresses in the management space.
//
// Behaviour
// RULE1: A 16-bit pin level readback register sits at offset 0x0F, bits 13..0 map to the pins and bits 15:14 are reserved read-only.
// RULE2: Reading the readback register returns the level sampled on each pin in its bit.
// RULE3: A 16-bit output value register sits at offset 0x10, bits 13..0 hold the value for each pin.
// RULE4: Output value bits 13..0 are writable, read back and clear to 0 at reset, bits 15:14 are reserved read-only.
// RULE5: A 16-bit direction register sits at offset 0x11 with one output enable bit per pin in bits 13..0.
// RULE6: Every direction bit resets to 0 so all pins start as inputs, and bits 15:14 are reserved read-only.
// RULE7: The three registers govern a pin only while its two-bit function select field holds 11; level readback is not gated by the code.
// RULE8: A pin with its output enable set is driven with its output bit, otherwise its driver is released.

package gpp_pkg;

  // ==========================================================
  // Geometry
  localparam int GPP_PIN_CNT = 14;
  localparam int GPP_REG_W = 16;
  localparam int GPP_ADDR_W = 5;
  localparam int GPP_SEL_W = 2;

  // ==========================================================
  // Register offsets
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_LEVEL = 5'h0F;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_OUT = 5'h10;
  localparam logic [GPP_ADDR_W-1:0] GPP_OFS_DIR = 5'h11;

  // ==========================================================
  // Field values and reset values
  localparam logic [GPP_SEL_W-1:0] GPP_SEL_GPIO = 2'h3;
  localparam logic [GPP_PIN_CNT-1:0] GPP_OUT_RST = 14'h0000;
  localparam logic [GPP_PIN_CNT-1:0] GPP_DIR_RST = 14'h0000;
  localparam logic [GPP_PIN_CNT-1:0] GPP_SYNC_RST = 14'h0000;
  localparam logic [GPP_REG_W-1:0] GPP_RDATA_RST = 16'h0000;
  localparam logic [GPP_REG_W-GPP_PIN_CNT-1:0] GPP_RESV_VAL = 2'h0;

endpackage

/* File: design/gpp_sync_if.sv */
// Purpose: Carries raw pin levels into the synchroniser and the clean levels back.
// Assumes: Both ends run on clk_sys.
// Notes:   Width follows the pin count of the port.
`timescale 1ns/1ps
`default_nettype none

interface gpp_sync_if;
  import gpp_pkg::*;

  logic [GPP_PIN_CNT-1:0] raw;
  logic [GPP_PIN_CNT-1:0] synced;

  modport user_side (output raw, input synced);
  modport sync_side (input raw, output synced);
endinterface

`default_nettype wire

/* File: design/gpp_sync.sv */
// Purpose: Two-flop synchroniser for the pin inputs.
// Assumes: Pin levels are asynchronous to clk_sys.
// Notes:   Only the second stage is visible to the rest of the port.
`timescale 1ns/1ps
`default_nettype none

module gpp_sync
(
  input wire logic clk_sys,
  input wire logic nrst,
  gpp_sync_if.sync_side sb
);
  import gpp_pkg::*;

  logic [GPP_PIN_CNT-1:0] meta_r;
  logic [GPP_PIN_CNT-1:0] clean_r;

  // ==========================================================
  // Stages
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= GPP_SYNC_RST;
      clean_r <= GPP_SYNC_RST;
    end
    else
    begin
      meta_r <= sb.raw;
      clean_r <= meta_r;
    end
  end

  assign sb.synced = clean_r;

endmodule

`default_nettype wire

/* File: design/gpp_top.sv */
// Purpose: General purpose pin port: level readback, output value and direction registers.
// Assumes: Register strobes come from management logic on clk_sys; pins are asynchronous.
// Notes:   Read data appears one cycle after the read strobe and then holds.
`timescale 1ns/1ps
`default_nettype none

module gpp_top
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [gpp_pkg::GPP_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [gpp_pkg::GPP_REG_W-1:0] reg_wdata,
  output logic [gpp_pkg::GPP_REG_W-1:0] reg_rdata,
  input wire logic [gpp_pkg::GPP_PIN_CNT*gpp_pkg::GPP_SEL_W-1:0] pin_func_sel,
  input wire logic [gpp_pkg::GPP_PIN_CNT-1:0] alt_out,
  input wire logic [gpp_pkg::GPP_PIN_CNT-1:0] alt_oe,
  input wire logic [gpp_pkg::GPP_PIN_CNT-1:0] pin_in,
  output logic [gpp_pkg::GPP_PIN_CNT-1:0] pin_out,
  output logic [gpp_pkg::GPP_PIN_CNT-1:0] pin_oe
);
  import gpp_pkg::*;

  // ==========================================================
  // Declarations
  logic [GPP_PIN_CNT-1:0] out_val_r;
  logic [GPP_PIN_CNT-1:0] dir_r;
  logic [GPP_REG_W-1:0] rdata_r;
  logic [GPP_REG_W-1:0] rdata_nxt;
  logic [GPP_PIN_CNT-1:0] pin_out_r;
  logic [GPP_PIN_CNT-1:0] pin_oe_r;
  logic [GPP_PIN_CNT-1:0] pin_out_nxt;
  logic [GPP_PIN_CNT-1:0] pin_oe_nxt;
  logic [GPP_PIN_CNT-1:0] gpio_mode;
  logic [GPP_PIN_CNT-1:0] pin_sync;
  logic wr_out;
  logic wr_dir;

  gpp_sync_if sync_bus ();

  // ==========================================================
  // Input synchroniser
  assign sync_bus.raw = pin_in;
  assign pin_sync = sync_bus.synced;

  gpp_sync u_sync (
    .clk_sys (clk_sys),
    .nrst (nrst),
    .sb (sync_bus.sync_side)
  );

  // ==========================================================
  // Write decode
  // RULE3 output value decode
  assign wr_out = reg_wr_en && (reg_addr == GPP_OFS_OUT);
  // RULE5 direction decode
  assign wr_dir = reg_wr_en && (reg_addr == GPP_OFS_DIR);

  // RULE4 output value storage
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      out_val_r <= GPP_OUT_RST;
    else if (wr_out)
      out_val_r <= reg_wdata[GPP_PIN_CNT-1:0];
  end

  // RULE6 direction storage, inputs at reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      dir_r <= GPP_DIR_RST;
    else if (wr_dir)
      dir_r <= reg_wdata[GPP_PIN_CNT-1:0];
  end

  // ==========================================================
  // Read path
  // Writes to the level register are dropped: it only mirrors the pins.
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (reg_rd_en)
    begin
      case (reg_addr)
        // RULE1 RULE2 pin level readback
        GPP_OFS_LEVEL: rdata_nxt = {GPP_RESV_VAL, pin_sync};
        // RULE4 output value readback
        GPP_OFS_OUT: rdata_nxt = {GPP_RESV_VAL, out_val_r};
        // RULE6 direction readback
        GPP_OFS_DIR: rdata_nxt = {GPP_RESV_VAL, dir_r};
        default: rdata_nxt = GPP_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= GPP_RDATA_RST;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // Pin drive
  // RULE7 function select gate
  always_comb
  begin
    for (int i = 0; i < GPP_PIN_CNT; i++)
    begin
      gpio_mode[i] = (pin_func_sel[i*GPP_SEL_W +: GPP_SEL_W] == GPP_SEL_GPIO);
    end
  end

  // RULE8 drive or release per pin
  assign pin_oe_nxt = (gpio_mode & dir_r) | (~gpio_mode & alt_oe);
  assign pin_out_nxt = (gpio_mode & out_val_r) | (~gpio_mode & alt_out);

  // Registered so the pad sees no decode glitches; costs one cycle of latency.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_oe_r <= GPP_DIR_RST;
      pin_out_r <= GPP_OUT_RST;
    end
    else
    begin
      pin_oe_r <= pin_oe_nxt;
      pin_out_r <= pin_out_nxt;
    end
  end

  assign pin_oe = pin_oe_r;
  assign pin_out = pin_out_r;

  // ==========================================================
  // Checks
  logic boot_r;
  logic warm_r;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      boot_r <= 1'h0;
    else
      boot_r <= 1'h1;
  end

  // Two edges after release the synchroniser holds real pin levels, not reset zeros
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      warm_r <= 1'h0;
    else
      warm_r <= boot_r;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence out_wr_s;
    reg_wr_en && (reg_addr == GPP_OFS_OUT) && (&gpio_mode);
  endsequence

  sequence gpio_hold_s;
    &gpio_mode;
  endsequence

  reset_vals_a: assert property ( // RULE6
    !boot_r |-> (dir_r == GPP_DIR_RST) && (out_val_r == GPP_OUT_RST) && (pin_oe == '0))
    else $error("registers not cleared after reset");

  out_store_a: assert property ( // RULE4
    reg_wr_en && (reg_addr == GPP_OFS_OUT)
    |=> out_val_r == $past(reg_wdata[GPP_PIN_CNT-1:0]))
    else $error("output value write lost");

  out_to_pin_a: assert property ( // RULE3
    out_wr_s ##1 gpio_hold_s |=> pin_out == $past(reg_wdata[GPP_PIN_CNT-1:0], 2))
    else $error("written output value not on pins");

  dir_read_a: assert property ( // RULE5
    reg_rd_en && (reg_addr == GPP_OFS_DIR)
    |=> reg_rdata == {GPP_RESV_VAL, $past(dir_r)})
    else $error("direction readback wrong");

  level_read_a: assert property ( // RULE2
    warm_r && reg_rd_en && (reg_addr == GPP_OFS_LEVEL)
    |=> reg_rdata[GPP_PIN_CNT-1:0] == $past(pin_in, 3))
    else $error("level readback does not follow pin");

  resv_zero_a: assert property ( // RULE1
    reg_rdata[GPP_REG_W-1:GPP_PIN_CNT] == GPP_RESV_VAL)
    else $error("reserved read bits not zero");

  unmapped_a: assert property ( // RULE1
    reg_rd_en && (reg_addr != GPP_OFS_LEVEL) && (reg_addr != GPP_OFS_OUT)
    && (reg_addr != GPP_OFS_DIR) |=> reg_rdata == GPP_RDATA_RST)
    else $error("unmapped read not zero");

  gpio_drive_a: assert property ( // RULE8
    gpio_hold_s |=> (pin_oe == $past(dir_r)) && (pin_out == $past(out_val_r)))
    else $error("pin drive does not follow registers");

  alt_owner_a: assert property ( // RULE7
    (gpio_mode != '1)
    |=> ((((pin_oe ^ $past(alt_oe)) | (pin_out ^ $past(alt_out))) & ~$past(gpio_mode)) == '0))
    else $error("registers drive a pin not in gpio mode");

  out_read_a: assert property ( // RULE4
    reg_rd_en && (reg_addr == GPP_OFS_OUT)
    |=> reg_rdata == {GPP_RESV_VAL, $past(out_val_r)})
    else $error("output value readback wrong");

  dir_store_a: assert property ( // RULE5
    reg_wr_en && (reg_addr == GPP_OFS_DIR)
    |=> dir_r == $past(reg_wdata[GPP_PIN_CNT-1:0]))
    else $error("direction write lost");

  level_wr_a: assert property ( // RULE1
    reg_wr_en && (reg_addr == GPP_OFS_LEVEL)
    |=> $stable(out_val_r) && $stable(dir_r))
    else $error("level register write changed a register");

endmodule

`default_nettype wire

/* File: tb/gpp_pins_model.sv */
// Purpose: External circuits attached to the pins.
// Assumes: No pull resistors on the pins.
// Notes:   A released pin shows the level the circuit drives.
`timescale 1ns/1ps
`default_nettype none

module gpp_pins_model
(
  input wire logic [gpp_pkg::GPP_PIN_CNT-1:0] pin_out,
  input wire logic [gpp_pkg::GPP_PIN_CNT-1:0] pin_oe,
  input wire logic [gpp_pkg::GPP_PIN_CNT-1:0] ext_lvl,
  output logic [gpp_pkg::GPP_PIN_CNT-1:0] pin_in
);
  import gpp_pkg::*;

  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

`default_nettype wire

/* File: tb/general_purpose_pin_port_test.sv */
// Purpose: Self-checking bench for the pin port registers and pins.
// Assumes: Inputs change on the falling edge of clk_sys.
// Notes:   Read data is sampled one falling edge after the strobe.
`timescale 1ns/1ps
`default_nettype none

module general_purpose_pin_port_test;
  import gpp_pkg::*;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [GPP_ADDR_W-1:0] reg_addr = 5'h00;
  logic reg_wr_en = 1'h0;
  logic reg_rd_en = 1'h0;
  logic [GPP_REG_W-1:0] reg_wdata = 16'h0000;
  logic [GPP_REG_W-1:0] reg_rdata;
  logic [GPP_PIN_CNT*GPP_SEL_W-1:0] sel = 28'hFFFFFFF;
  logic [GPP_PIN_CNT-1:0] alt_out = 14'h0000;
  logic [GPP_PIN_CNT-1:0] alt_oe = 14'h0000;
  logic [GPP_PIN_CNT-1:0] ext_lvl = 14'h0000;
  logic [GPP_PIN_CNT-1:0] pin_in;
  logic [GPP_PIN_CNT-1:0] pin_out;
  logic [GPP_PIN_CNT-1:0] pin_oe;
  int fails = 0;
  int checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  gpp_top dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_func_sel(sel), .alt_out(alt_out), .alt_oe(alt_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe));
  gpp_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'h1;
    @(negedge clk_sys);
    reg_wr_en = 1'h0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_en = 1'h1;
    @(negedge clk_sys);
    reg_rd_en = 1'h0;
    chk(reg_rdata, exp);
  endtask

  task automatic give_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Tests need about 40 cycles; allow fifty times that
  initial
  begin
    #(2000 * 25);
    fails++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(negedge clk_sys);
    nrst = 1'h1;
    rd(GPP_OFS_OUT, 16'h0000);
    rd(GPP_OFS_DIR, 16'h0000);
    chk({2'h0, pin_oe}, 16'h0000);
    $display("test reset done");
    wr(GPP_OFS_OUT, 16'hD2B4);
    rd(GPP_OFS_OUT, 16'h12B4);
    wr(GPP_OFS_DIR, 16'hFFFF);
    rd(GPP_OFS_DIR, 16'h3FFF);
    chk({2'h0, pin_oe}, 16'h3FFF);
    chk({2'h0, pin_out}, 16'h12B4);
    repeat (3) @(negedge clk_sys);
    rd(GPP_OFS_LEVEL, 16'h12B4);
    wr(GPP_OFS_LEVEL, 16'hFFFF);
    rd(GPP_OFS_OUT, 16'h12B4);
    $display("test drive done");
    ext_lvl = 14'h2A55;
    wr(GPP_OFS_DIR, 16'h0000);
    repeat (4) @(negedge clk_sys);
    chk({2'h0, pin_oe}, 16'h0000);
    rd(GPP_OFS_LEVEL, 16'h2A55);
    rd(5'h12, 16'h0000);
    $display("test input done");
    sel = {{13{2'h3}}, 2'h0};
    alt_oe = 14'h0001;
    alt_out = 14'h0001;
    wr(GPP_OFS_DIR, 16'h0002);
    repeat (2) @(negedge clk_sys);
    chk({2'h0, pin_oe}, 16'h0003);
    chk({2'h0, pin_out & 14'h0003}, 16'h0001);
    $display("test select done");
    give_verdict();
  end
endmodule

`default_nettype wire
